// >>> rtl/eep_pkg.sv
// Package for the data EEPROM program control block.
// Assumes a single 125 MHz core clock and a byte-wide data space bus.
package eep_pkg;
    // Control register location and reset value.
    localparam logic [7:0] ADDR_CTRL = 8'hDF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Control register bit positions.
    localparam int BIT_ENABLE = 0;
    localparam int BIT_BUSY = 1;
    localparam int BIT_ROW_WRITE_MODE = 2;
    localparam int BIT_PSTART = 3;
    localparam int BIT_STANDBY = 6;
    // EEPROM window in data space: 00h..3Fh, two pages.
    localparam logic [7:0] WINDOW_END = 8'h40;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] READ_MISS = 8'h00;
    // Row geometry: eight bytes per row.
    localparam int ROW_BYTES = 8;
    localparam int ROWS = 16;
    // Programming time of one cycle and its length in core clocks.
    localparam int PROG_TIME_US = 5000;
    localparam int CLK_MHZ = 125;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int CNT_W = 20;
endpackage : eep_pkg

// >>> rtl/eep_if.sv
// Interface between the control logic and the EEPROM cell array.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface eep_if;
    logic start; // One-cycle request to program the staged row.
    logic [3:0] row; // Row address of the staged bytes.
    logic [7:0] mask; // One bit per loaded byte of the row.
    logic [63:0] data; // Eight staged bytes, byte 0 in the low bits.
    logic standby; // Array powered down.
    logic [6:0] rd_addr; // Read address into the array.
    logic [7:0] rd_data; // Read data from the array.
    logic busy; // Programming in progress.
    logic done; // One-cycle pulse when programming ends.
    modport ctrl (output start, row, mask, data, standby, rd_addr,
                  input rd_data, busy, done);
    modport arr (input start, row, mask, data, standby, rd_addr,
                 output rd_data, busy, done);
endinterface : eep_if

// >>> rtl/eep_array.sv
// EEPROM cell array with its programming timer.
// Assumes start is a one-cycle pulse raised only while not busy.
`timescale 1ns/1ps
module eep_array #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control side.
    eep_if.arr bus
);
    logic [7:0] mem_q [0:127]; // Nonvolatile cells.
    logic [eep_pkg::CNT_W-1:0] cnt_q; // Remaining programming cycles.
    logic busy_q; // Timer running.
    logic done_q; // End pulse.
    logic [3:0] row_q; // Row being programmed.
    logic [7:0] mask_q; // Bytes being programmed.
    logic [63:0] data_q; // Data being programmed.

    // Busy shows in the very cycle of the start so no access slips in, and it
    // also covers the end pulse so that no access meets the end of programming.
    assign bus.busy = busy_q | bus.start | done_q;
    assign bus.done = done_q;
    // Reads return nothing useful while powered down.
    assign bus.rd_data = bus.standby ? eep_pkg::READ_MISS : mem_q[bus.rd_addr];

    // Timer: load on start, count down, pulse done at the end.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            row_q <= '0;
            mask_q <= '0;
            data_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (bus.start && !busy_q) begin
                cnt_q <= eep_pkg::CNT_W'(PROG_CYCLES - 1);
                busy_q <= 1'b1;
                row_q <= bus.row;
                mask_q <= bus.mask;
                data_q <= bus.data;
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    // Cells: erased at reset, only loaded bytes change at the end.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) begin
                mem_q[i] <= eep_pkg::ERASED;
            end
        end else if (busy_q && cnt_q == '0) begin
            for (int b = 0; b < eep_pkg::ROW_BYTES; b++) begin
                if (mask_q[b]) begin
                    mem_q[{row_q, 3'(b)}] <= data_q[8*b +: 8];
                end
            end
        end
    end
endmodule : eep_array

// >>> rtl/eep_ctrl.sv
// Data EEPROM program control: control register, row latches, access gating.
// Assumes the core drives addr, wdata and the strobes from the same clock,
// and that the bank register outside supplies the one-hot page select.
`timescale 1ns/1ps
// Function
// - Control register at DFh, reset 00h.
// - Standby bit disables access, minimum power.
// - Bit 7 does nothing.
// - Start bit programs the latched row.
// - Start bit clears itself at end.
// - Only loaded row bytes are programmed.
// - Mode bit lets eight row writes latch.
// - Row is A7..A3, byte is A2..A0; the code takes the row from page_sel[1] and A5..A3.
// - Mode bit clears at end of programming.
// - Clearing mode before start abandons row.
// - Busy flag follows programming cycle.
// - Accesses during busy are aborted.
// - Writes with enable low do nothing; in row mode the code still loads them into the row latches.
// - Unprogrammed bytes read FFh.
// - Busy blocks control writes, busy readable.
// - Mode set clears latches, latches row.
// - Start needs enable and mode set.
module eep_ctrl #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Core data space bus.
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Bank select from the bank register: bit 0 page 0, bit 1 page 1.
    input wire logic [1:0] page_sel
);
    // Reset synchroniser. Only the second flop feeds the logic, so a release
    // that lands near a clock edge cannot leave half of the block in reset.
    logic rst_m_q; // First reset flop.
    logic rst_sync_n; // Released reset used everywhere.
    // Stored control bits. The busy flag is not among them: it is read straight
    // from the array, so it can never disagree with the programming timer.
    logic enable_q; // Programming enable.
    logic standby_q; // Standby select.
    logic row_write_mode_q; // Parallel mode enable.
    logic pstart_q; // Parallel start.
    // Staging toward the array. The latches are volatile and are only handed
    // over together with the start pulse.
    logic start_q; // Start pulse to the array.
    logic row_valid_q; // Row address has been latched.
    logic [3:0] row_q; // Latched row.
    logic [7:0] mask_q; // Loaded bytes of the row.
    logic [63:0] lat_q; // Volatile row latches.
    logic [7:0] rdata_q; // Read data register.
    // Decoded strobes. The accepted strobes already carry the window, busy and standby refusals, so
    // the processes below only add the enable low and foreign-row refusals and order the cases.
    logic busy; // Programming in progress.
    logic done; // Programming ended.
    logic ctl_wr; // Accepted control register write.
    logic ctl_hit; // Control register addressed.
    logic eep_wr; // Accepted EEPROM write.
    logic eep_rd; // Accepted EEPROM read.
    logic [6:0] eep_idx; // EEPROM byte index.
    logic go; // Written value asks for a parallel start.

    // The cell array sits behind one interface bundle; it keeps its own timer
    // so that the control side needs no knowledge of the programming time.
    eep_if link ();

    // The array runs from the released reset too, so it never leaves reset
    // before the control bits that drive it.
    eep_array #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_array (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .bus(link)
    );

    // Release reset through two flops; assertion stays asynchronous.
    // The first usable edge is the third rising edge after the pin rises;
    // a request before it is lost without trace.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_sync_n <= rst_m_q;
        end
    end

    // EEPROM window hit: low 64 bytes with exactly one page selected.
    // With no page or two pages selected nothing answers, which keeps a bad
    // bank setting from writing two halves of the array at once.
    function automatic logic eep_hit(input logic [7:0] a, input logic [1:0] p);
        eep_hit = (a < eep_pkg::WINDOW_END) && (p == 2'b01 || p == 2'b10);
    endfunction : eep_hit

    // Busy covers the start pulse, the whole timer run and the end cycle, so
    // no write can meet the end of programming and be silently dropped.
    // The end pulse therefore always falls inside busy.
    assign busy = link.busy;
    assign done = link.done;
    assign eep_idx = {page_sel[1], addr[5:0]};
    assign ctl_hit = (addr == eep_pkg::ADDR_CTRL);
    // Control writes are locked out for the whole programming cycle.
    // A write in that time is lost; software is expected to poll first.
    assign ctl_wr = wr && ctl_hit && !busy;
    // Accesses in standby or during programming are dropped.
    // A dropped access leaves no trace apart from the read value.
    assign eep_wr = wr && eep_hit(addr, page_sel) && !busy && !standby_q;
    assign eep_rd = rd && eep_hit(addr, page_sel) && !busy && !standby_q;
    // Start only when enable and mode are both written set.
    // All three bits must arrive in one write, which is how software is
    // expected to give the start in any case.
    assign go = wdata[eep_pkg::BIT_PSTART] && wdata[eep_pkg::BIT_ENABLE]
                && wdata[eep_pkg::BIT_ROW_WRITE_MODE];

    // Array side. The read address follows the bus directly; the array read is
    // asynchronous and the result is registered below.
    assign link.rd_addr = eep_idx;
    assign link.standby = standby_q;
    assign link.start = start_q;
    assign link.row = row_q;
    assign link.mask = mask_q;
    assign link.data = lat_q;
    assign rdata = rdata_q;

    // Control bits. Bits 7, 5 and 4 are not stored at all.
    // The end of programming takes precedence over a write; both cannot meet,
    // since writes are refused for as long as busy stands.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            enable_q <= eep_pkg::CTRL_RESET[eep_pkg::BIT_ENABLE];
            standby_q <= eep_pkg::CTRL_RESET[eep_pkg::BIT_STANDBY];
            row_write_mode_q <= eep_pkg::CTRL_RESET[eep_pkg::BIT_ROW_WRITE_MODE];
            pstart_q <= eep_pkg::CTRL_RESET[eep_pkg::BIT_PSTART];
        end else if (done) begin
            pstart_q <= 1'b0;
            row_write_mode_q <= 1'b0;
        end else if (ctl_wr) begin
            enable_q <= wdata[eep_pkg::BIT_ENABLE];
            standby_q <= wdata[eep_pkg::BIT_STANDBY];
            row_write_mode_q <= wdata[eep_pkg::BIT_ROW_WRITE_MODE];
            pstart_q <= go;
        end
    end

    // Start pulse: parallel start from the register, or a byte write.
    // The pulse is registered so that the latches written on the same edge
    // are settled when the array takes them one cycle later.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= (ctl_wr && go)
                       || (eep_wr && enable_q && !row_write_mode_q);
        end
    end

    // Row latches. A byte write reuses them as a one-byte row.
    // Sharing the latches saves a separate byte path; the price is that a
    // byte write overwrites one latch, which is harmless because parallel
    // mode always starts again from cleared latches.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            row_valid_q <= 1'b0;
            row_q <= '0;
            mask_q <= '0;
            lat_q <= '0;
        end else if (done) begin
            // The row is free again once programming has ended.
            row_valid_q <= 1'b0;
            mask_q <= '0;
        end else if (ctl_wr && !wdata[eep_pkg::BIT_ROW_WRITE_MODE]) begin
            // Leaving parallel mode discards what was loaded.
            row_valid_q <= 1'b0;
            mask_q <= '0;
        end else if (ctl_wr && !row_write_mode_q) begin
            // Entering parallel mode starts from empty latches.
            row_valid_q <= 1'b0;
            mask_q <= '0;
        end else if (eep_wr && row_write_mode_q && !pstart_q) begin
            // Writes to another row than the latched one are lost.
            // Only the row address is compared; the byte index may repeat.
            if (!row_valid_q || row_q == eep_idx[6:3]) begin
                row_valid_q <= 1'b1;
                row_q <= eep_idx[6:3];
                mask_q[eep_idx[2:0]] <= 1'b1;
                lat_q[8*eep_idx[2:0] +: 8] <= wdata;
            end
        end else if (eep_wr && enable_q && !row_write_mode_q) begin
            // Byte mode stages exactly one byte.
            row_q <= eep_idx[6:3];
            mask_q <= 8'h01 << eep_idx[2:0];
            lat_q[8*eep_idx[2:0] +: 8] <= wdata;
        end
    end

    // Read data. Only the busy flag is visible in the control register.
    // Refused reads return a fixed value rather than stale data, so software
    // that skips the busy poll sees an obviously wrong byte.
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= eep_pkg::CTRL_RESET;
        end else if (rd && ctl_hit) begin
            rdata_q <= 8'(busy) << eep_pkg::BIT_BUSY;
        end else if (eep_rd) begin
            rdata_q <= link.rd_data;
        end else if (rd) begin
            rdata_q <= eep_pkg::READ_MISS;
        end
    end

    // Checks run on the core clock and sleep while the released reset is low.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_sync_n);

    a_ctl_write_locked: assert property (
        (wr && ctl_hit && busy && !done) |=>
        {enable_q, standby_q, row_write_mode_q, pstart_q} ==
        {$past(enable_q), $past(standby_q), $past(row_write_mode_q), $past(pstart_q)})
        else $error("Control bits changed while busy.");
    a_end_clears_mode: assert property (
        done |=> !row_write_mode_q && !pstart_q)
        else $error("Mode or start bit survived end of programming.");
    a_start_needs_bits: assert property (
        pstart_q |-> enable_q && row_write_mode_q)
        else $error("Start bit set without enable and mode.");
    a_disabled_write_idle: assert property (
        (wr && eep_hit(addr, page_sel) && !enable_q && !ctl_wr) |=> !start_q)
        else $error("Write with enable low started programming.");
    a_abandon_clears_row: assert property (
        (ctl_wr && !wdata[eep_pkg::BIT_ROW_WRITE_MODE] && !done) |=> mask_q == 8'h00)
        else $error("Row latches kept after mode cleared.");
    a_mode_rise_clears: assert property (
        (ctl_wr && wdata[eep_pkg::BIT_ROW_WRITE_MODE] && !row_write_mode_q) |=> mask_q == 8'h00)
        else $error("Row latches not cleared on entering mode.");
    a_busy_follows_start: assert property (
        start_q |-> busy ##1 busy)
        else $error("Busy not raised for a programming cycle.");
    a_busy_ends_on_done: assert property (
        $fell(busy) |-> $past(done))
        else $error("Busy dropped without end of programming.");
    a_busy_read_value: assert property (
        (rd && ctl_hit) |=> rdata_q == {6'h00, $past(busy), 1'b0})
        else $error("Control read does not show busy alone.");
    a_standby_no_start: assert property (
        (wr && eep_hit(addr, page_sel) && standby_q) |=> !start_q)
        else $error("Write in standby started programming.");
    a_busy_aborts: assert property (
        (wr && eep_hit(addr, page_sel) && busy) |=> !start_q)
        else $error("Write during busy started programming.");

    // Start pulse shape, refused reads and the latch bookkeeping of the row.
    // These watch internal state that the bus alone shows only indirectly.
    a_start_one_pulse: assert property (
        start_q |=> !start_q)
        else $error("Start pulse lasted more than one cycle.");
    a_start_from_idle: assert property (
        start_q |-> !$past(busy))
        else $error("Start pulse raised from a busy cycle.");
    a_busy_read_blank: assert property (
        (rd && eep_hit(addr, page_sel) && busy) |=> rdata_q == eep_pkg::READ_MISS)
        else $error("Read during busy returned cell data.");
    a_standby_read_blank: assert property (
        (rd && eep_hit(addr, page_sel) && standby_q) |=> rdata_q == eep_pkg::READ_MISS)
        else $error("Read in standby returned cell data.");
    a_foreign_row_kept: assert property (
        (eep_wr && row_write_mode_q && !pstart_q && row_valid_q && row_q != eep_idx[6:3])
        |=> $stable(mask_q))
        else $error("Write to a foreign row changed the loaded bytes.");
    a_row_write_latched: assert property (
        (eep_wr && row_write_mode_q && !pstart_q) |=> row_valid_q)
        else $error("Row address not latched by a parallel write.");
    a_byte_single_mask: assert property (
        (eep_wr && enable_q && !row_write_mode_q) |=> $onehot(mask_q))
        else $error("Byte write staged other than one byte.");
    a_done_after_busy: assert property (
        done |-> $past(busy))
        else $error("End of programming without a busy cycle.");
    a_start_bit_holds: assert property (
        (pstart_q && !done) |=> pstart_q)
        else $error("Start bit cleared before programming ended.");
    a_abandon_no_start: assert property (
        (ctl_wr && !wdata[eep_pkg::BIT_ROW_WRITE_MODE]) |=> !start_q)
        else $error("Clearing mode started programming.");
    a_enable_low_no_start: assert property (
        (ctl_wr && !wdata[eep_pkg::BIT_ENABLE]) |=> !pstart_q && !start_q)
        else $error("Start accepted with enable low.");

    // Main scenarios that a test run should reach.
    c_byte_program: cover property (eep_wr && enable_q && !row_write_mode_q ##1 start_q);
    c_row_program: cover property (ctl_wr && go && mask_q != 8'h00 ##1 start_q);
    c_row_abandon: cover property (ctl_wr && !wdata[eep_pkg::BIT_ROW_WRITE_MODE] && mask_q != 8'h00);
    c_program_end: cover property (done);
    c_busy_status_read: cover property (rd && ctl_hit && busy);
endmodule : eep_ctrl

// >>> tb/eep_cpu_model.sv
// CPU core model: issues whole-byte data space reads and writes to the block.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module eep_cpu_model (
    // Clock.
    input wire logic ref_clk,
    // Data space bus toward the block.
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    // Page select, as the bank register would drive it.
    output logic [1:0] page_sel
);
    // The bus idles with no strobe and page 0 selected.
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        page_sel = 2'h1;
    end

    // One write cycle; the control register is only ever written as a byte.
    task bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge ref_clk);
        wr = 1'b0;
        // Stale data must not look valid once the strobe is gone.
        wdata = ~d;
    endtask : bus_wr

    // One read cycle; data is registered, so it is taken after the edge.
    task bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        rd = 1'b1;
        @(negedge ref_clk);
        rd = 1'b0;
        d = rdata;
    endtask : bus_rd

    // Polls busy until clear, bounded so a stuck flag cannot hang the run.
    task poll_idle(output logic [7:0] st);
        int n;
        n = 0;
        st = 8'h02;
        while (st[1] !== 1'b0 && n < 64) begin
            bus_rd(8'hDF, st);
            n++;
        end
    endtask : poll_idle

    // Changes the EEPROM page between accesses only.
    task set_page(input logic [1:0] p);
        @(negedge ref_clk);
        page_sel = p;
    endtask : set_page
endmodule : eep_cpu_model

// >>> tb/tb_eep_ctrl.sv
// Self-checking bench for the EEPROM program control block.
// Assumes the CPU model drives the bus; programming time is shortened.
`timescale 1ns/1ps
module tb_eep_ctrl;
    // A short program time keeps the run small; busy must still outlast the accesses that t_byte makes in it, and end within the poll bound.
    localparam int PROG = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic [1:0] page_sel;
    int miscompares = 0;
    int compares = 0;

    // Free-running 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    eep_ctrl #(.PROG_CYCLES(PROG)) eep_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .page_sel(page_sel));
    eep_cpu_model eep_cpu_model_i (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .page_sel(page_sel));

    // Compares one byte result and reports a mismatch at once.
    task check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check_byte

    // Reads one location and compares it.
    task rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        eep_cpu_model_i.bus_rd(a, d);
        check_byte(what, exp, d);
    endtask : rd_chk

    // Waits for programming to end; the last status read must show idle.
    task wait_idle();
        logic [7:0] st;
        eep_cpu_model_i.poll_idle(st);
        check_byte("status after poll", 8'h00, st);
    endtask : wait_idle

    // Prints the counts and the verdict, then ends the run.
    task end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Reset state, and writes refused while programming is not enabled.
    task t_reset_and_locked();
        rd_chk(8'hDF, 8'h00, "control at reset");
        rd_chk(8'h3F, 8'hFF, "erased cell");
        eep_cpu_model_i.bus_wr(8'h05, 8'h55);
        rd_chk(8'hDF, 8'h00, "busy after locked write");
        rd_chk(8'h05, 8'hFF, "cell after locked write");
        eep_cpu_model_i.bus_wr(8'hDF, 8'h09);
        rd_chk(8'hDF, 8'h00, "busy after start without mode");
    endtask : t_reset_and_locked

    // Byte write, with a control write and a read attempted during busy.
    task t_byte();
        eep_cpu_model_i.bus_wr(8'hDF, 8'h01);
        eep_cpu_model_i.bus_wr(8'h05, 8'hAA);
        rd_chk(8'hDF, 8'h02, "busy in byte cycle");
        eep_cpu_model_i.bus_wr(8'hDF, 8'h41);
        rd_chk(8'h05, 8'h00, "read during busy");
        wait_idle();
        rd_chk(8'h05, 8'hAA, "byte programmed, standby refused");
    endtask : t_byte

    // Row write of three bytes, then proof that the mode bit cleared itself.
    task t_row();
        logic [7:0] exp [8];
        exp = '{8'h11, 8'hFF, 8'h22, 8'h33, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        eep_cpu_model_i.bus_wr(8'hDF, 8'h05);
        eep_cpu_model_i.bus_wr(8'h18, 8'h11);
        eep_cpu_model_i.bus_wr(8'h1A, 8'h22);
        eep_cpu_model_i.bus_wr(8'h1B, 8'h33);
        eep_cpu_model_i.bus_wr(8'hDF, 8'h0D);
        rd_chk(8'hDF, 8'h02, "busy after row start");
        wait_idle();
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'h18 + i[7:0], exp[i], "row byte");
        end
        // A write now must be a byte write, so a stuck mode bit would show.
        eep_cpu_model_i.bus_wr(8'h1F, 8'h44);
        rd_chk(8'hDF, 8'h02, "byte cycle after row");
        wait_idle();
        rd_chk(8'h1F, 8'h44, "byte after row");
    endtask : t_row

    // Abandoned row, reload after re-entry, and a foreign-row write.
    task t_abandon();
        eep_cpu_model_i.bus_wr(8'hDF, 8'h05);
        eep_cpu_model_i.bus_wr(8'h20, 8'h66);
        eep_cpu_model_i.bus_wr(8'hDF, 8'h01);
        rd_chk(8'hDF, 8'h00, "busy after abandon");
        eep_cpu_model_i.bus_wr(8'hDF, 8'h05);
        eep_cpu_model_i.bus_wr(8'h21, 8'h77);
        eep_cpu_model_i.bus_wr(8'h28, 8'h99);
        eep_cpu_model_i.bus_wr(8'hDF, 8'h0D);
        wait_idle();
        rd_chk(8'h20, 8'hFF, "abandoned byte");
        rd_chk(8'h21, 8'h77, "reloaded byte");
        rd_chk(8'h28, 8'hFF, "foreign row byte");
    endtask : t_abandon

    // Standby blocks access; bit 7 is ignored; page 1 is a separate array half.
    task t_standby_page();
        eep_cpu_model_i.bus_wr(8'hDF, 8'h41);
        eep_cpu_model_i.bus_wr(8'h06, 8'hBB);
        rd_chk(8'hDF, 8'h00, "busy in standby");
        rd_chk(8'h05, 8'h00, "read in standby");
        eep_cpu_model_i.bus_wr(8'hDF, 8'h81);
        eep_cpu_model_i.bus_wr(8'h06, 8'hBB);
        rd_chk(8'hDF, 8'h02, "busy with bit 7 set");
        wait_idle();
        eep_cpu_model_i.set_page(2'h2);
        eep_cpu_model_i.bus_wr(8'h05, 8'hCC);
        wait_idle();
        rd_chk(8'h05, 8'hCC, "page 1 byte");
        eep_cpu_model_i.set_page(2'h1);
        rd_chk(8'h05, 8'hAA, "page 0 byte kept");
        rd_chk(8'h06, 8'hBB, "byte after bit 7 write");
    endtask : t_standby_page

    // Main sequence: reset, wait out the synchroniser, run the scenarios.
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset_and_locked();
        t_byte();
        t_row();
        t_abandon();
        t_standby_page();
        end_of_test();
    end

    // The scenarios need well under a thousand cycles; 50 us means a hang.
    initial begin
        #50000;
        miscompares++;
        end_of_test();
    end
endmodule : tb_eep_ctrl
